// [core/gst_pkg.sv]
// Purpose: constants and types for the generator-set sequencer
// Assumes: 200 MHz pclk, APB register access
// Notes: scheduler positions are 15-minute slots
package gst_pkg;
  // ==========================================================
  // clock and timer base
  localparam int CLK_NS = 5;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] A_MODE = 8'h00;
  localparam logic [7:0] A_CFG = 8'h04;
  localparam logic [7:0] A_TIM0 = 8'h08;
  localparam logic [7:0] A_TIM1 = 8'h0c;
  localparam logic [7:0] A_TIM2 = 8'h10;
  localparam logic [7:0] A_ATT = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  localparam logic [1:0] A_ENT_HI = 2'h1;
  // ==========================================================
  // config bits
  localparam int CF_ONLOAD = 0;
  localparam int CF_INH_EN = 1;
  localparam int CF_LOADED = 2;
  localparam int CF_PER0 = 3;
  localparam int CF_PER1 = 4;
  localparam int CF_FSRC = 5;
  localparam int CF_OILREL = 7;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [31:0] TIM_RST = 32'h000a_000a;
  localparam logic [3:0] ATT_RST = 4'h3;
  // ==========================================================
  // scheduler entry layout and cycle lengths
  localparam int EN_BIT = 31;
  localparam int TY_LO = 29;
  localparam logic [1:0] TY_OFF = 2'h0;
  localparam logic [1:0] TY_ON = 2'h1;
  localparam logic [1:0] TY_INH = 2'h2;
  localparam logic [11:0] SLOT_WK = 12'h2a0;
  localparam logic [11:0] SLOT_4WK = 12'ha80;
  // ==========================================================
  typedef enum logic [1:0] {
    MD_STOP = 2'h0, MD_MAN = 2'h1, MD_AUTO = 2'h2, MD_TEST = 2'h3
  } gst_mode_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_SDLY = 4'h1, ST_CRANK = 4'h3, ST_REST = 4'h2,
    ST_SAFE = 4'h6, ST_RUN = 4'h7, ST_RDLY = 4'h5, ST_COOL = 4'h4,
    ST_FAIL = 4'hc
  } gst_state_t;
endpackage

// [core/gst_seq.sv]
// Purpose: test/auto sequencer with exercise scheduler
// Assumes: buttons are one-cycle pulses synchronous to pclk
// Notes: timers count common ticks; limits set over APB
// Contract
// - test start cranks at once, no delay
// - failed crank rests, retries, then fails
// - starter released when selected source fires
// - safety-on delay suppresses faults after crank
// - load held off until generator available
// - test mode puts load on generator
// - test mode never drops load by itself
// - stop drops load and engine at once
// - auto from test keeps requests and timers
// - panel lock blocks mode changes
// - auto start request sources ORed
// - start delay, withdrawn request returns idle
// - request at delay end starts cranking
// - auto run on load if configured
// - return delay; request returns on load
// - then mains, cooldown, stop engine
// - scheduled runs only in clean auto
// - on-load entry forces load while running
// - entering auto inside window starts engine
// - external input inhibits scheduled runs
`timescale 1ns/1ps
module gst_seq
  import gst_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // operator buttons and inputs
  input wire logic btn_stop,
  input wire logic btn_man,
  input wire logic btn_test,
  input wire logic btn_auto,
  input wire logic btn_start,
  input wire logic btn_open_gen,
  input wire logic panel_lock,
  input wire logic load_inhibit,
  // start request sources
  input wire logic mains_fail,
  input wire logic remote_start,
  input wire logic aux_mains_fail,
  input wire logic telem_start,
  input wire logic dms_start,
  // engine and alarms
  input wire logic fire_freq,
  input wire logic fire_pickup,
  input wire logic fire_ecu,
  input wire logic oil_rising,
  input wire logic gen_avail,
  input wire logic shutdown_alarm,
  input wire logic sched_inhibit_in,
  input wire logic slot_tick,
  // outputs
  output logic fuel_on,
  output logic crank_on,
  output logic safety_on,
  output logic gen_load,
  output logic fail_start
);
  // ==========================================================
  // registers
  gst_mode_t mode_q;
  gst_state_t st_q, st_d;
  logic [7:0] cfg_q;
  logic [31:0] tim0_q, tim1_q, tim2_q;
  logic [3:0] att_max_q, att_q;
  logic [31:0] ent_q [16];
  logic [11:0] slot_q;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic [15:0] tmr_q, lim;
  logic done, fired, start_req, load_req;
  logic ld_hold_q, gen_load_q;
  logic s_run, s_on, s_inh, sched_ok;
  logic wr, rd;
  logic [31:0] rd_d;
  logic dec_ok;

  function automatic logic [11:0] pos_in(input logic [11:0] s,
                                          input logic four);
    logic [11:0] p;
    p = s;
    if (!four)
    begin
      for (int k = 0; k < 3; k++)
        if (p >= SLOT_WK)
          p = p - SLOT_WK;
    end
    return p;
  endfunction

  function automatic logic win_hit(input logic [11:0] pos,
                                   input logic [31:0] e,
                                   input logic [11:0] per);
    logic [12:0] d;
    d = (pos >= e[11:0]) ? {1'b0, pos} - {1'b0, e[11:0]}
                         : {1'b0, pos} + {1'b0, per} - {1'b0, e[11:0]};
    return e[EN_BIT] && (d < {1'b0, e[23:12]});
  endfunction

  // ==========================================================
  // apb slave: data captured in setup, answered in access
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  always_comb
  begin
    rd_d = 32'h0000_0000;
    dec_ok = 1'b1;
    if (paddr[7:6] == A_ENT_HI)
      rd_d = ent_q[paddr[5:2]];
    else
      unique case (paddr)
        A_MODE: rd_d = {30'h0, mode_q};
        A_CFG: rd_d = {24'h0, cfg_q};
        A_TIM0: rd_d = tim0_q;
        A_TIM1: rd_d = tim1_q;
        A_TIM2: rd_d = tim2_q;
        A_ATT: rd_d = {24'h0, att_q, att_max_q};
        A_STAT: rd_d = {20'h0, s_inh, s_on, s_run, gen_load_q,
                        fail_start, safety_on, 2'h0, st_q};
        default: dec_ok = 1'b0;
      endcase
  end
  assign pslverr = psel && penable && !dec_ok;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd)
      prdata <= rd_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cfg_q <= CFG_RST;
      tim0_q <= TIM_RST;
      tim1_q <= TIM_RST;
      tim2_q <= TIM_RST;
      att_max_q <= ATT_RST;
      for (int i = 0; i < 16; i++)
        ent_q[i] <= 32'h0000_0000;
    end
    else if (wr)
    begin
      if (paddr[7:6] == A_ENT_HI)
        ent_q[paddr[5:2]] <= pwdata;
      else if (paddr == A_CFG)
        cfg_q <= pwdata[7:0];
      else if (paddr == A_TIM0)
        tim0_q <= pwdata;
      else if (paddr == A_TIM1)
        tim1_q <= pwdata;
      else if (paddr == A_TIM2)
        tim2_q <= pwdata;
      else if (paddr == A_ATT)
        att_max_q <= pwdata[3:0];
    end

  // ==========================================================
  // mode: one register, so exactly one mode at a time
  // apb write to the mode word acts like the matching button
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mode_q <= MD_STOP;
    else if (!panel_lock)
    begin
      if (btn_stop)
        mode_q <= MD_STOP;
      else if (btn_auto)
        mode_q <= MD_AUTO;
      else if (btn_test)
        mode_q <= MD_TEST;
      else if (btn_man)
        mode_q <= MD_MAN;
      else if (wr && paddr == A_MODE)
        mode_q <= gst_mode_t'(pwdata[1:0]);
    end

  // ==========================================================
  // common tick and per-state timer
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      tick_cnt_q <= 32'h0000_0000;
    else if (tick)
      tick_cnt_q <= 32'h0000_0000;
    else
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      tmr_q <= 16'h0000;
    else if (st_d != st_q)
      tmr_q <= 16'h0000;
    else if (tick && !done)
      tmr_q <= tmr_q + 16'h0001;

  always_comb
    unique case (st_q)
      ST_SDLY: lim = tim0_q[15:0];
      ST_CRANK: lim = tim0_q[31:16];
      ST_REST: lim = tim1_q[15:0];
      ST_SAFE: lim = tim1_q[31:16];
      ST_RDLY: lim = tim2_q[15:0];
      ST_COOL: lim = tim2_q[31:16];
      default: lim = 16'hffff;
    endcase
  assign done = (tmr_q >= lim);

  // ==========================================================
  // scheduler: slot clock from the real-time source
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      slot_q <= 12'h000;
    else if (slot_tick)
      slot_q <= (slot_q == SLOT_4WK - 12'h001) ? 12'h000
                                               : slot_q + 12'h001;

  always_comb
  begin
    s_run = 1'b0;
    s_on = 1'b0;
    s_inh = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      // bank select: entries 0-7 and 8-15 carry own period
      logic four;
      four = (i < 8) ? cfg_q[CF_PER0] : cfg_q[CF_PER1];
      if (cfg_q[CF_LOADED] && win_hit(pos_in(slot_q, four), ent_q[i],
                                      four ? SLOT_4WK : SLOT_WK))
      begin
        if (ent_q[i][TY_LO+:2] == TY_INH)
          s_inh = 1'b1;
        else
          s_run = 1'b1;
        if (ent_q[i][TY_LO+:2] == TY_ON)
          s_on = 1'b1;
      end
    end
  end
  // level, so entering auto inside a window requests a start
  assign sched_ok = (mode_q == MD_AUTO) && !shutdown_alarm && !s_inh
                    && !(cfg_q[CF_INH_EN] && sched_inhibit_in);

  // ==========================================================
  // start requests and fire detection
  assign start_req = (mode_q == MD_AUTO) && (mains_fail || remote_start
                     || aux_mains_fail || telem_start || dms_start
                     || (sched_ok && s_run));

  always_comb
  begin
    unique case (cfg_q[CF_FSRC+:2])
      2'h1: fired = fire_pickup;
      2'h2: fired = fire_ecu;
      default: fired = fire_freq;
    endcase
    // oil pressure only ends cranking, no speed protection
    if (cfg_q[CF_OILREL] && oil_rising)
      fired = 1'b1;
  end

  // ==========================================================
  // sequence
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE:
        if ((mode_q == MD_TEST || mode_q == MD_MAN) && btn_start)
          st_d = ST_CRANK;
        else if (start_req)
          st_d = ST_SDLY;
      ST_SDLY:
        if (!start_req)
          st_d = ST_IDLE;
        else if (done)
          st_d = ST_CRANK;
      ST_CRANK:
        if (fired)
          st_d = ST_SAFE;
        else if (done)
          st_d = (att_q >= att_max_q) ? ST_FAIL : ST_REST;
      ST_REST:
        if (done)
          st_d = ST_CRANK;
      ST_SAFE:
        if (done)
          st_d = ST_RUN;
      ST_RUN:
        if (mode_q == MD_AUTO && !start_req)
          st_d = ST_RDLY;
      ST_RDLY:
        if (start_req)
          st_d = ST_RUN;
        else if (done)
          st_d = ST_COOL;
      ST_COOL:
        if (start_req)
          st_d = ST_RUN;
        else if (done)
          st_d = ST_IDLE;
      ST_FAIL:
        st_d = ST_FAIL;
      default:
        st_d = ST_IDLE;
    endcase
    // stop mode ends everything at once, no timers
    if (mode_q == MD_STOP)
      st_d = ST_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      st_q <= ST_IDLE;
    else
      st_q <= st_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      att_q <= 4'h0;
    else if (st_q != ST_CRANK && st_d == ST_CRANK)
      att_q <= att_q + 4'h1;
    else if (st_d == ST_IDLE)
      att_q <= 4'h0;

  // ==========================================================
  // load: test holds load until an operator action removes it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ld_hold_q <= 1'b0;
    else if (mode_q == MD_TEST)
      ld_hold_q <= 1'b1;
    else if (mode_q != MD_MAN || btn_open_gen)
      ld_hold_q <= 1'b0;

  always_comb
    unique case (mode_q)
      MD_TEST: load_req = 1'b1;
      MD_MAN: load_req = ld_hold_q || s_on;
      MD_AUTO: load_req = cfg_q[CF_ONLOAD] || (sched_ok && s_on);
      default: load_req = 1'b0;
    endcase

  // stays on load through the return delay, off in cooldown
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      gen_load_q <= 1'b0;
    else
      gen_load_q <= load_req && gen_avail && !load_inhibit
                    && (st_d == ST_RUN || st_d == ST_RDLY);

  // ==========================================================
  // outputs
  assign gen_load = gen_load_q;
  assign fuel_on = (st_q == ST_CRANK) || (st_q == ST_REST)
                   || (st_q == ST_SAFE) || (st_q == ST_RUN)
                   || (st_q == ST_RDLY) || (st_q == ST_COOL);
  assign crank_on = (st_q == ST_CRANK);
  assign safety_on = (st_q == ST_SAFE);
  assign fail_start = (st_q == ST_FAIL);

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_test_start_now: assert property ((st_q == ST_IDLE && mode_q == MD_TEST
      && btn_start && !(btn_stop && !panel_lock)) |=> crank_on && fuel_on)
    else $error("test start did not crank at once");
  a_crank_retry: assert property ((st_q == ST_CRANK && !fired && done
      && att_q < att_max_q && st_d != ST_IDLE) |=> !crank_on && st_q == ST_REST)
    else $error("failed crank did not rest");
  a_fail_cause: assert property ($rose(fail_start) |-> $past(st_q) == ST_CRANK
      && $past(att_q) >= $past(att_max_q))
    else $error("fail to start without exhausted attempts");
  a_fire_release: assert property ((crank_on && fired && mode_q != MD_STOP)
      |=> !crank_on && safety_on)
    else $error("starter not released on fire");
  a_load_avail: assert property (gen_load |-> $past(gen_avail))
    else $error("load closed without generator available");
  a_stop_drop: assert property ((btn_stop && !panel_lock) |=> ##1
      (!gen_load && !fuel_on && !crank_on))
    else $error("stop did not drop load and engine");
  a_lock_mode: assert property (panel_lock |=> $stable(mode_q))
    else $error("mode changed under panel lock");
  a_sdly_abort: assert property ((st_q == ST_SDLY && !start_req) |=> st_q == ST_IDLE
      && !crank_on)
    else $error("withdrawn request still started");
  a_cool_end: assert property ((st_q == ST_COOL && done && !start_req
      && mode_q != MD_STOP) |=> !fuel_on ##1 !fuel_on)
    else $error("engine not stopped after cooldown");
  a_test_keep: assert property ((mode_q == MD_TEST && gen_load && gen_avail
      && !load_inhibit && st_q == ST_RUN && !btn_stop && !btn_auto && !btn_man)
      |=> gen_load)
    else $error("test mode dropped load by itself");

  c_auto_run: cover property (st_q == ST_SDLY ##[1:300] st_q == ST_RUN);
  c_fail: cover property ($rose(fail_start));
  c_cool_stop: cover property (st_q == ST_COOL ##1 st_q == ST_IDLE);
  c_back_on: cover property (st_q == ST_RDLY ##1 st_q == ST_RUN);
endmodule // gst_seq

// [sim/gst_engine_model.sv]
// Purpose: engine, starter and alternator seen by the sequencer
// Assumes: fires after a fixed spell of cranking when allowed
// Notes: bench decides whether it fires and when it gives power
`timescale 1ns/1ps
module gst_engine_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // controller outputs
  input wire logic fuel_on,
  input wire logic crank_on,
  input wire logic safety_on,
  // bench controls
  input wire logic fire_ok,
  input wire logic avail_ok,
  // engine feedback
  output logic fire_freq,
  output logic oil_rising,
  output logic gen_avail
);
  // ==========================================================
  // engine state
  logic [3:0] spin_q;
  logic run_q;
  // a dead engine never fires, so retry logic is really exercised
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      spin_q <= 4'h0;
      run_q <= 1'b0;
    end
    else
    begin
      spin_q <= (crank_on && spin_q != 4'hf) ? spin_q + 4'h1 : (crank_on ? spin_q : 4'h0);
      run_q <= fuel_on && (run_q || (fire_ok && spin_q == 4'h8));
    end
  end
  assign fire_freq = run_q;
  assign oil_rising = run_q;
  // power only once the protections are armed
  assign gen_avail = run_q && avail_ok && !safety_on;
endmodule // gst_engine_model

// [sim/gst_seq_bench.sv]
// Purpose: self-checking bench for the sequencer
// Assumes: tick shortened to 4 cycles
// Notes: request sources picked from a fixed-seed lfsr
`timescale 1ns/1ps
module gst_seq_bench;
  import gst_pkg::*;
  // ==========================================================
  // signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, crank_base;
  logic [31:0] crank_rises = 32'h0000_0000;
  logic btn_stop, btn_man, btn_test, btn_auto, btn_start, btn_open_gen;
  logic panel_lock, load_inhibit, fire_ok, avail_ok, err, shutdown_alarm, slot_tick;
  logic crank_prev = 1'b0;
  logic [4:0] req;
  logic fire_freq, oil_rising, gen_avail;
  logic fuel_on, crank_on, safety_on, gen_load, fail_start;
  logic [15:0] seed;
  int errors, total_checks, idx;
  // ==========================================================
  // design and partner
  gst_seq #(.TICK_CYCLES(4)) gst_seq_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .btn_stop(btn_stop), .btn_man(btn_man),
    .btn_test(btn_test), .btn_auto(btn_auto), .btn_start(btn_start),
    .btn_open_gen(btn_open_gen), .panel_lock(panel_lock), .load_inhibit(load_inhibit),
    .mains_fail(req[0]), .remote_start(req[1]), .aux_mains_fail(req[2]),
    .telem_start(req[3]), .dms_start(req[4]), .fire_freq(fire_freq), .fire_pickup(1'b0),
    .fire_ecu(1'b0), .oil_rising(oil_rising), .gen_avail(gen_avail),
    .shutdown_alarm(shutdown_alarm), .sched_inhibit_in(1'b0), .slot_tick(slot_tick),
    .fuel_on(fuel_on),
    .crank_on(crank_on), .safety_on(safety_on), .gen_load(gen_load),
    .fail_start(fail_start));
  gst_engine_model gst_engine_model_i (.pclk(pclk), .presetn(presetn), .fuel_on(fuel_on),
    .crank_on(crank_on), .safety_on(safety_on), .fire_ok(fire_ok), .avail_ok(avail_ok),
    .fire_freq(fire_freq), .oil_rising(oil_rising), .gen_avail(gen_avail));
  // ==========================================================
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic pick(input int w);
    case (w)
      0: pick = fuel_on;
      1: pick = crank_on;
      2: pick = safety_on;
      3: pick = gen_load;
      default: pick = fail_start;
    endcase
  endfunction
  task automatic summarize();
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // bounded wait; a run-out is counted and ends the run
  task automatic waitv(input int w, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(w) !== v && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    chk(32'(pick(w)), 32'(v));
    if (pick(w) !== v)
      summarize();
  endtask
  task automatic hold_chk(input int w, input logic v, input int cyc);
    repeat (cyc)
    begin
      @(posedge pclk);
      if (pick(w) !== v)
        break;
    end
    chk(32'(pick(w)), 32'(v));
  endtask
  task automatic press(input int w);
    @(posedge pclk);
    case (w)
      0: btn_stop <= 1'b1;
      1: btn_test <= 1'b1;
      2: btn_auto <= 1'b1;
      default: btn_start <= 1'b1;
    endcase
    @(posedge pclk);
    {btn_stop, btn_test, btn_auto, btn_start} <= 4'h0;
  endtask
  // scheduler slot clock: one pulse per slot
  task automatic slots(input int cnt);
    repeat (cnt)
    begin
      @(posedge pclk);
      slot_tick <= 1'b1;
      @(posedge pclk);
      slot_tick <= 1'b0;
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      chk(32'(pready), 32'h1);
      summarize();
    end
  endtask
  // ==========================================================
  // clock, reset, watchdog
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    crank_prev <= crank_on;
    if (crank_on === 1'b1 && crank_prev === 1'b0)
      crank_rises <= crank_rises + 32'h1;
  end
  initial
  begin
    repeat (60000) @(posedge pclk);
    errors++;
    summarize();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {btn_stop, btn_man, btn_test, btn_auto, btn_start, btn_open_gen} = '0;
    {panel_lock, load_inhibit, req, shutdown_alarm, slot_tick} = '0;
    {fire_ok, avail_ok} = 2'b10;
    seed = 16'h834e;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({fuel_on, crank_on, gen_load, fail_start}, 4'h0);
    apb(1'b0, A_CFG, '0);
    chk(rd, 32'(CFG_RST));
    apb(1'b0, A_TIM0, '0);
    chk(rd, TIM_RST);
    apb(1'b0, A_ATT, '0);
    chk(rd[3:0], ATT_RST);
    apb(1'b0, 8'h3c, '0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0000_0000);
    apb(1'b1, A_TIM0, 32'h0006_0004);
    apb(1'b1, A_TIM1, 32'h0003_0003);
    apb(1'b1, A_TIM2, 32'h0004_0004);
    apb(1'b1, A_ATT, 32'h2);
    apb(1'b1, A_CFG, 32'h1);
    // test mode: start, fire, load, inhibit, stop
    press(1);
    press(3);
    waitv(1, 1'b1, 2);
    chk(32'(fuel_on), 32'h1);
    waitv(1, 1'b0, 80);
    chk(32'(safety_on), 32'h1);
    hold_chk(3, 1'b0, 60);
    avail_ok <= 1'b1;
    waitv(3, 1'b1, 20);
    hold_chk(3, 1'b1, 80);
    load_inhibit <= 1'b1;
    waitv(3, 1'b0, 5);
    load_inhibit <= 1'b0;
    waitv(3, 1'b1, 5);
    press(0);
    waitv(0, 1'b0, 3);
    chk(32'(gen_load), 32'h0);
    // dead engine: retries then gives up
    fire_ok <= 1'b0;
    press(1);
    crank_base = crank_rises;
    press(3);
    waitv(4, 1'b1, 400);
    chk(crank_rises - crank_base, 32'h2);
    chk(32'(crank_on), 32'h0);
    press(0);
    fire_ok <= 1'b1;
    // auto: a glitch of a request, then every source in turn
    press(2);
    seed = lfsr(seed);
    idx = int'(seed % 16'h5);
    req[idx] <= 1'b1;
    repeat (1 + int'(seed[2:0])) @(posedge pclk);
    req <= '0;
    hold_chk(1, 1'b0, 80);
    for (int i = 0; i < 5; i++)
    begin
      req[i] <= 1'b1;
      waitv(1, 1'b1, 40);
      waitv(3, 1'b1, 200);
      req <= '0;
      repeat (6) @(posedge pclk);
      chk(32'(gen_load), 32'h1);
      if (i == 0)
      begin
        seed = lfsr(seed);
        req[int'(seed % 16'h5)] <= 1'b1;
        hold_chk(3, 1'b1, 40);
        req <= '0;
      end
      waitv(3, 1'b0, 60);
      chk(32'(fuel_on), 32'h1);
      waitv(0, 1'b0, 60);
    end
    // mode buttons locked out
    panel_lock <= 1'b1;
    press(1);
    repeat (2) @(posedge pclk);
    apb(1'b0, A_MODE, '0);
    chk(rd[1:0], MD_AUTO);
    panel_lock <= 1'b0;
    // ==========================================================
    // scheduler: one on-load window, held off while an alarm stands
    apb(1'b1, {A_ENT_HI, 6'h00}, 32'ha000_3002);
    apb(1'b1, A_CFG, 32'h4);
    shutdown_alarm <= 1'b1;
    slots(2);
    hold_chk(1, 1'b0, 40);
    shutdown_alarm <= 1'b0;
    waitv(1, 1'b1, 40);
    waitv(3, 1'b1, 200);
    slots(3);
    waitv(3, 1'b0, 60);
    waitv(0, 1'b0, 60);
    summarize();
  end
endmodule // gst_seq_bench
